// [dv/fup_programmer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module fup_programmer_bench;
   logic clk_sys = 0, reset_n = 0, external_reset_pin = 0, supply_sense_reset = 0;
   logic bus_wr = 0, bus_rd = 0, insn_done = 0, irq_in = 0;
   logic [15:0] bus_addr = 16'h0000, base = 16'h0000;
   logic [7:0] bus_wdata = 8'h00, v;
   logic [7:0] mem [128];
   wire logic [7:0] bus_rdata, ram_rdata;
   wire logic [9:0] ram_addr;
   wire logic cpu_hold, irq_out, ram_rd, block_invalid;
   wire fup_pkg::fup_flash_s flash_q;
   int fails = 0, comparisons = 0, nwr = 0, cyc = 0, seed = 33, i, last = 0, per = 4;
   always #25 clk_sys = ~clk_sys;
   // staging ram answers from the low seven address bits
   assign ram_rdata = mem[ram_addr[6:0]];
   fup_programmer #(.INHIBIT_COUNT(20)) fup_programmer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .clk_en(1'h1), .external_reset_pin(external_reset_pin), .supply_sense_reset(supply_sense_reset),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .insn_done(insn_done), .cpu_hold(cpu_hold), .irq_in(irq_in), .irq_out(irq_out), .ram_addr(ram_addr),
      .ram_rd(ram_rd), .ram_rdata(ram_rdata), .flash_q(flash_q), .flash_ready(1'h1),
      .block_invalid(block_invalid));
   task automatic give_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'h1;
      @(posedge clk_sys);
      bus_wr <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'h1;
      @(posedge clk_sys);
      bus_rd <= 1'h0;
      #1 v = bus_rdata;
   endtask
   // load target, optionally unlock with random high nibbles, then trigger
   task automatic start(input logic [15:0] a, input bit arm, input logic [7:0] ctl);
      base = {a[15:7], 7'h00};
      nwr = 0;
      wr(16'h00F2, a[7:0]);
      wr(16'h00F3, a[15:8]);
      if (arm)
      begin
         // select 00 divides by 16, each step up halves the divisor
         per = 16 >> {ctl[4], ctl[3]};
         wr(16'h00F0, {4'($random(seed)), 4'h5});
         wr(16'h00F0, {4'($random(seed)), 4'hA});
      end
      wr(16'h00F1, ctl);
      insn_done <= 1'h0;
   endtask
   task automatic prog(input logic [15:0] a, input int abort, input logic [7:0] ctl);
      start(a, 1'h1, ctl);
      irq_in <= 1'h1;
      repeat (3) @(posedge clk_sys);
      #1 chk(cpu_hold, 1'h0);
      insn_done <= 1'h1;
      @(posedge clk_sys);
      insn_done <= 1'h0;
      @(posedge clk_sys);
      #1 chk(cpu_hold, 1'h1);
      repeat (abort + 20) @(posedge clk_sys);
      #1 chk(irq_out, 1'h0);
      if (abort > 0)
      begin
         external_reset_pin <= 1'h1;
         repeat (2) @(posedge clk_sys);
         external_reset_pin <= 1'h0;
         #1 chk(cpu_hold, 1'h0);
         chk(block_invalid, 1'h1);
      end
      else
      begin
         for (i = 0; i < 8000 && cpu_hold !== 1'h0; i++) @(posedge clk_sys) #1;
         chk(16'(nwr), 16'h0080);
         chk(block_invalid, 1'h0);
         rd(16'h00F4);
         chk(v[0], 1'h0);
         rd(16'h00F4);
         chk(v[1], 1'h0);
         chk(irq_out, 1'h1);
      end
      irq_in <= 1'h0;
   endtask
   // reference model of the copy, plus the hang limit
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         give_verdict();
      end
      if (flash_q.req === 1'h1 && flash_q.erase === 1'h0)
      begin
         chk(flash_q.addr, base + 16'(nwr));
         chk(16'(flash_q.data), 16'(mem[nwr[6:0]]));
         // a staging read and a flash write take one transfer tick each
         if (nwr > 0)
            chk(16'(cyc - last), 16'(2 * per));
         last = cyc;
         nwr++;
      end
   end
   initial
   begin
      for (i = 0; i < 128; i++) mem[i] = 8'($random(seed));
      repeat (12) @(posedge clk_sys); // oscillator settled long before flash is used
      reset_n <= 1'h1;
      // right after power-up: idle, not armed, locked out
      rd(16'h00F4);
      chk(v, 8'h04);
      supply_sense_reset <= 1'h1;
      @(posedge clk_sys);
      supply_sense_reset <= 1'h0;
      rd(16'h00F4);
      chk(v[2], 1'h1);
      start(16'h5537, 1'h1, 8'h11);
      rd(16'h00F4);
      chk(v[0], 1'h0);
      repeat (30) @(posedge clk_sys);
      prog(16'h5537, 0, 8'h11); // targets never hold the running routine
      // no fresh unlock: the trigger must be refused
      start(16'h5537, 1'h0, 8'h11);
      insn_done <= 1'h1;
      @(posedge clk_sys);
      insn_done <= 1'h0;
      repeat (3) @(posedge clk_sys);
      #1 chk(cpu_hold, 1'h0);
      prog(16'h1280, 600, 8'h11);
      prog(16'h1280, 0, 8'h11);
      // both select bits low: the slowest transfer clock
      prog(16'h0F80, 0, 8'h01);
      give_verdict();
   end
endmodule // fup_programmer_bench
`default_nettype wire

// [dv/fup_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fup_props (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic external_reset_pin,
   input wire logic supply_sense_reset,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic insn_done,
   input wire logic cpu_hold,
   input wire logic irq_out,
   input wire logic [9:0] ram_addr,
   input wire logic ram_rd,
   input wire fup_pkg::fup_flash_s flash_q,
   input wire logic block_invalid
);
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_irq_held_off: assert property (cpu_hold |-> !irq_out)
      else $error("interrupt passed during hold");
   a_hold_after_insn: assert property ($rose(cpu_hold) |-> $past(insn_done, 2) || $past(insn_done))
      else $error("hold without the grace instruction");
   a_flash_held: assert property (flash_q.req |-> cpu_hold)
      else $error("flash request outside hold");
   a_ram_window: assert property (ram_rd |-> ram_addr >= 10'h300 && ram_addr <= 10'h37F)
      else $error("staging read outside window");
   a_abort_now: assert property ($rose(external_reset_pin) && cpu_hold |-> ##[1:2] !cpu_hold)
      else $error("reset pin did not end hold");
   a_abort_marks: assert property ($rose(external_reset_pin) && cpu_hold |-> ##[1:2] block_invalid)
      else $error("aborted block not marked");
   a_inhibit_hold: assert property ($fell(supply_sense_reset) |-> !cpu_hold [*8])
      else $error("hold during inhibit");
   a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("read data outside its cycle");
   // main scenarios: hold entry, clean finish, abort
   cover property ($rose(cpu_hold));
   cover property ($fell(cpu_hold) && !block_invalid);
   cover property ($rose(block_invalid));
endmodule // fup_props
bind fup_programmer fup_props fup_props_inst (.*);
`default_nettype wire

// [rtl/fup_pkg.sv]
package fup_pkg;
   localparam logic [15:0] ADDR_ACCEPTOR = 16'h00F0;
   localparam logic [15:0] ADDR_CONTROL = 16'h00F1;
   localparam logic [15:0] ADDR_TARGET = 16'h00F2;
   localparam logic [15:0] ADDR_STATUS = 16'h00F4;
   localparam int CTL_TRIGGER = 0;
   localparam int CTL_CLK_LO = 3;
   localparam int CTL_CLK_HI = 4;
   localparam int CTL_AMP_OFF = 5;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [3:0] UNLOCK_FIRST = 4'h5;
   localparam logic [3:0] UNLOCK_SECOND = 4'hA;
   localparam logic [9:0] RAM_BASE = 10'h300;
   localparam int BLOCK_BYTES = 128;
   localparam int BLOCK_LSB = 7;
   localparam int CLK_HZ = 20_000_000;
   localparam int INHIBIT_MS = 20;
   localparam int INHIBIT_CYCLES = CLK_HZ / 1000 * INHIBIT_MS;
   localparam int ERASE_CYCLES = 64;
   typedef enum logic [2:0] {FUP_IDLE, FUP_GRACE, FUP_ERASE, FUP_WRITE, FUP_DONE} fup_state_e;
   typedef struct packed
   {
      logic req;
      logic [15:0] addr;
      logic [7:0] data;
      logic erase;
   } fup_flash_s;
endpackage

// [rtl/fup_programmer.sv]
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fup_programmer #(
   parameter int INHIBIT_COUNT = fup_pkg::INHIBIT_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic external_reset_pin,
   input wire logic supply_sense_reset,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic insn_done,
   output logic cpu_hold,
   input wire logic irq_in,
   output logic irq_out,
   output logic [9:0] ram_addr,
   output logic ram_rd,
   input wire logic [7:0] ram_rdata,
   output fup_pkg::fup_flash_s flash_q,
   input wire logic flash_ready,
   output logic block_invalid
);
   fup_pkg::fup_state_e state_q;
   logic acceptor_q;
   logic [3:0] last_nibble_q;
   logic last_was_acc_q;
   logic trigger_q;
   logic [1:0] clk_sel_q;
   logic amp_off_q;
   logic [15:7] target_q;
   logic [22:0] inhibit_q;
   logic [3:0] div_q;
   logic [6:0] idx_q;
   logic [7:0] erase_q;
   logic pend_q;
   logic rd_pend_q;
   logic tick;
   logic wr_acc;
   logic wr_ctl;
   logic busy;
   logic start_ok;
   // programming ends immediately on the reset pin
   assign busy = (state_q != fup_pkg::FUP_IDLE);
   assign wr_acc = bus_wr && (bus_addr == fup_pkg::ADDR_ACCEPTOR);
   assign wr_ctl = bus_wr && (bus_addr == fup_pkg::ADDR_CONTROL);
   assign start_ok = (inhibit_q == 23'h00_0000);
   // transfer clock: sel 00 gives /16, then /8, /4, /2
   always_comb
   begin
      unique case (clk_sel_q)
         2'b00: tick = (div_q == 4'hF);
         2'b01: tick = (div_q[2:0] == 3'h7);
         2'b10: tick = (div_q[1:0] == 2'h3);
         default: tick = div_q[0];
      endcase
   end
   // free-running divider for the transfer clock
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         div_q <= 4'h0;
      else if (clk_en)
         div_q <= div_q + 4'h1;
   end
   // programming lockout after power-up and after a supply-sense reset
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         inhibit_q <= 23'(INHIBIT_COUNT);
      else if (clk_en)
      begin
         if (supply_sense_reset)
            inhibit_q <= 23'(INHIBIT_COUNT);
         else if (inhibit_q != 23'h00_0000)
            inhibit_q <= inhibit_q - 23'h00_0001;
      end
   end
   // power-on is the asynchronous reset: the lockout starts full, and the first cycle is refused too
   logic por_armed_q;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         por_armed_q <= 1'b0;
      else if (clk_en)
         por_armed_q <= 1'b1;
   end
   // acceptor tracks n5H followed directly by nAH
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acceptor_q <= 1'b0;
         last_nibble_q <= 4'h0;
         last_was_acc_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (external_reset_pin)
         begin
            acceptor_q <= 1'b0;
            last_was_acc_q <= 1'b0;
         end
         else if (state_q == fup_pkg::FUP_DONE)
            acceptor_q <= 1'b0;
         else if (bus_wr)
         begin
            last_was_acc_q <= wr_acc;
            last_nibble_q <= bus_wdata[3:0];
            if (wr_acc && last_was_acc_q && last_nibble_q == fup_pkg::UNLOCK_FIRST
                && bus_wdata[3:0] == fup_pkg::UNLOCK_SECOND)
               acceptor_q <= 1'b1;
         end
      end
   end
   // control and target address registers
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         trigger_q <= 1'b0;
         clk_sel_q <= 2'b00;
         amp_off_q <= 1'b0;
         target_q <= 9'h000;
      end
      else if (clk_en)
      begin
         if (external_reset_pin)
         begin
            trigger_q <= 1'b0;
            clk_sel_q <= 2'b00;
            amp_off_q <= 1'b0;
         end
         else if (state_q == fup_pkg::FUP_DONE)
            trigger_q <= 1'b0;
         else
         begin
            if (wr_ctl)
               amp_off_q <= bus_wdata[fup_pkg::CTL_AMP_OFF];
            // locked bits only land while armed and idle
            if (wr_ctl && acceptor_q && !busy)
            begin
               trigger_q <= bus_wdata[fup_pkg::CTL_TRIGGER] && start_ok && por_armed_q;
               clk_sel_q <= {bus_wdata[fup_pkg::CTL_CLK_HI], bus_wdata[fup_pkg::CTL_CLK_LO]};
            end
            if (bus_wr && bus_addr == fup_pkg::ADDR_TARGET && !busy)
               target_q <= bus_wdata[7:7] == 1'b1 ? {target_q[15:8], 1'b1} : {target_q[15:8], 1'b0};
            if (bus_wr && bus_addr == fup_pkg::ADDR_TARGET + 16'h0001 && !busy)
               target_q[15:8] <= bus_wdata;
         end
      end
   end
   // sequencer: grace instruction, erase, byte writes, done
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= fup_pkg::FUP_IDLE;
         idx_q <= 7'h00;
         erase_q <= 8'h00;
         rd_pend_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (external_reset_pin)
            state_q <= fup_pkg::FUP_IDLE;
         else
         begin
            unique case (state_q)
               fup_pkg::FUP_IDLE:
                  if (trigger_q)
                     state_q <= fup_pkg::FUP_GRACE;
               fup_pkg::FUP_GRACE:
                  if (insn_done)
                  begin
                     state_q <= fup_pkg::FUP_ERASE;
                     erase_q <= 8'h00;
                  end
               fup_pkg::FUP_ERASE:
                  if (tick && flash_ready)
                  begin
                     erase_q <= erase_q + 8'h01;
                     if (erase_q == 8'(fup_pkg::ERASE_CYCLES - 1))
                     begin
                        state_q <= fup_pkg::FUP_WRITE;
                        idx_q <= 7'h00;
                        rd_pend_q <= 1'b0;
                     end
                  end
               fup_pkg::FUP_WRITE:
                  if (tick && flash_ready)
                  begin
                     rd_pend_q <= !rd_pend_q;
                     if (rd_pend_q)
                     begin
                        idx_q <= idx_q + 7'h01;
                        if (idx_q == 7'(fup_pkg::BLOCK_BYTES - 1))
                           state_q <= fup_pkg::FUP_DONE;
                     end
                  end
               fup_pkg::FUP_DONE:
                  state_q <= fup_pkg::FUP_IDLE;
               default:
                  state_q <= fup_pkg::FUP_IDLE;
            endcase
         end
      end
   end
   // flash and ram strobes, hold, interrupt gating, read port
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flash_q <= '0;
         ram_addr <= 10'h000;
         ram_rd <= 1'b0;
         cpu_hold <= 1'b0;
         irq_out <= 1'b0;
         pend_q <= 1'b0;
         block_invalid <= 1'b0;
         bus_rdata <= 8'h00;
      end
      else if (clk_en)
      begin
         flash_q.req <= 1'b0;
         ram_rd <= 1'b0;
         flash_q.addr <= {target_q, 7'h00} | {9'h000, idx_q};
         // no strobe may leave on the abort edge, or the hold would drop under a live request
         if (state_q == fup_pkg::FUP_ERASE && tick && flash_ready && !external_reset_pin)
         begin
            flash_q.req <= 1'b1;
            flash_q.erase <= 1'b1;
         end
         if (state_q == fup_pkg::FUP_WRITE && tick && flash_ready && !external_reset_pin)
         begin
            if (!rd_pend_q)
            begin
               ram_addr <= fup_pkg::RAM_BASE + {3'h0, idx_q};
               ram_rd <= 1'b1;
            end
            else
            begin
               flash_q.req <= 1'b1;
               flash_q.erase <= 1'b0;
               flash_q.data <= ram_rdata;
            end
         end
         cpu_hold <= !external_reset_pin && (state_q == fup_pkg::FUP_ERASE || state_q == fup_pkg::FUP_WRITE
                     || (state_q == fup_pkg::FUP_GRACE && insn_done));
         // a request during the hold is latched, so a short pulse still reaches the cpu afterwards
         if (busy && state_q != fup_pkg::FUP_DONE)
            pend_q <= pend_q || irq_in;
         else
            pend_q <= 1'b0;
         irq_out <= (irq_in || pend_q) && !(busy && state_q != fup_pkg::FUP_DONE);
         if (external_reset_pin && (state_q == fup_pkg::FUP_ERASE || state_q == fup_pkg::FUP_WRITE))
            block_invalid <= 1'b1;
         else if (state_q == fup_pkg::FUP_DONE)
            block_invalid <= 1'b0;
         // registers read as ones, status reads own state
         if (bus_rd)
            bus_rdata <= (bus_addr == fup_pkg::ADDR_STATUS) ?
                         {3'h0, amp_off_q, block_invalid, !start_ok, acceptor_q, busy} : 8'hFF;
         else
            bus_rdata <= 8'h00;
      end
   end
endmodule // fup_programmer
`default_nettype wire
